// *** core/bcc_regs.svh ***
// Register offsets, field positions, reset values for the bus common control block
`ifndef BCC_REGS_SVH
`define BCC_REGS_SVH
`define BCC_COMMON_CONTROL_OFFSET 8'h00
`define BCC_MAP_BIT               12
`define BCC_RSVD_ONE_HI_BIT       4
`define BCC_ENDIAN_BIT            3
`define BCC_RSVD_ONE_LO_BIT       2
`define BCC_MEM_DRIVE_BIT         1
`define BCC_CLK_DRIVE_BIT         0
`define BCC_WRITE_MASK            32'h0000_1003
`define BCC_FIXED_ONES            32'h0000_0014
`define BCC_RESET_VALUE           32'h0000_0014
`endif

// *** core/bcc_pkg.sv ***
// Types shared by the bus common control block
package bcc_pkg;
    typedef struct packed {
        logic map_select;
        logic little_endian;
        logic memory_pins_standby_drive;
        logic clock_pins_standby_drive;
    } bcc_ctrl_t;
    typedef struct packed {
        logic memory_pins_oe;
        logic clock_pins_oe;
    } bcc_pin_oe_t;
endpackage

// *** core/bcc_strap_latch.sv ***
// Catches the byte-order strap at the release of reset
module bcc_strap_latch
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Strap
    input  wire logic byte_order_strap_pin,
    output logic      little_endian
);
    logic in_reset_reg;
    logic little_endian_reg;

    // Sample during reset so the flag is valid from the first free cycle
    always_ff @(posedge clk)
    begin
        in_reset_reg <= rst;
        if (rst || in_reset_reg)
            little_endian_reg <= byte_order_strap_pin;
    end

    // Flag out
    assign little_endian = little_endian_reg;
endmodule

// *** core/bcc_common_control.sv ***
// Bus common control register with classic Wishbone slave
`include "bcc_regs.svh"
module bcc_common_control
(
    // Clock and reset
    input  wire logic               clk,
    input  wire logic               rst,
    // Wishbone slave
    input  wire logic               wb_cyc_i,
    input  wire logic               wb_stb_i,
    input  wire logic               wb_we_i,
    input  wire logic [7:0]         wb_adr_i,
    input  wire logic [3:0]         wb_sel_i,
    input  wire logic [31:0]        wb_dat_i,
    output logic      [31:0]        wb_dat_o,
    output logic                    wb_ack_o,
    output logic                    wb_err_o,
    // Strap and standby
    input  wire logic               byte_order_strap_pin,
    input  wire logic               standby,
    // Settings to the external bus logic
    output bcc_pkg::bcc_ctrl_t      ctrl,
    output bcc_pkg::bcc_pin_oe_t    pin_oe
);
    // Stored fields; every other bit of the word is fixed or strapped
    logic        map_reg;
    logic        map_next;
    logic        mem_drive_reg;
    logic        mem_drive_next;
    logic        clk_drive_reg;
    logic        clk_drive_next;

    // Bus answer state
    logic        ack_reg;
    logic        ack_next;
    logic        err_reg;
    logic        err_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;

    // Strap result; only a reset can change it
    logic        little_endian;

    // Reset image and fixed pattern of the word
    localparam logic [31:0] RESET_WORD = `BCC_RESET_VALUE;
    localparam logic [31:0] FIXED_WORD = `BCC_FIXED_ONES;

    // Strap catcher
    bcc_strap_latch bcc_strap_latch_i
    (
        .clk                  (clk),
        .rst                  (rst),
        .byte_order_strap_pin (byte_order_strap_pin),
        .little_endian        (little_endian)
    );

    // Request qualification; a cycle is taken once and answered once
    wire         cyc_stb   = wb_cyc_i && wb_stb_i;
    wire         answering = ack_reg || err_reg;
    wire         take      = cyc_stb && !answering;

    // Address decode; one word lives at its offset, anything else gets err
    wire         hit       = wb_adr_i == `BCC_COMMON_CONTROL_OFFSET;
    wire         take_hit  = take && hit;
    wire         take_miss = take && !hit;
    wire         take_read = take_hit && !wb_we_i;

    // Writes land at the edge where the master sees ack, so an abandoned cycle writes nothing
    wire         commit    = cyc_stb && ack_reg && hit && wb_we_i;

    // Only bytes 1 and 0 hold writable bits; lanes 3 and 2 are all reserved
    wire         wr_b1     = commit && wb_sel_i[1];
    wire         wr_b0     = commit && wb_sel_i[0];

    // Write data for the three stored bits
    wire         map_wdata = wb_dat_i[`BCC_MAP_BIT];
    wire         mem_wdata = wb_dat_i[`BCC_MEM_DRIVE_BIT];
    wire         clk_wdata = wb_dat_i[`BCC_CLK_DRIVE_BIT];

    // Next values; an unselected lane keeps its bits
    assign map_next       = wr_b1 ? map_wdata : map_reg;
    assign mem_drive_next = wr_b0 ? mem_wdata : mem_drive_reg;
    assign clk_drive_next = wr_b0 ? clk_wdata : clk_drive_reg;

    // Map select; map 0 after reset
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            map_reg <= RESET_WORD[`BCC_MAP_BIT];
        end
        else
        begin
            map_reg <= map_next;
        end
    end

    // Memory pin standby drive; pins float after reset
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            mem_drive_reg <= RESET_WORD[`BCC_MEM_DRIVE_BIT];
        end
        else
        begin
            mem_drive_reg <= mem_drive_next;
        end
    end

    // Clock pin standby drive; pins float after reset
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            clk_drive_reg <= RESET_WORD[`BCC_CLK_DRIVE_BIT];
        end
        else
        begin
            clk_drive_reg <= clk_drive_next;
        end
    end

    // Read view per bit; reserved and strapped places have no storage, so writes miss them
    wire  [31:0] reg_view;
    genvar       pos;
    generate
        for (pos = 0; pos < 32; pos++)
        begin : g_view
            if (pos == `BCC_MAP_BIT)
            begin : g_map
                assign reg_view[pos] = map_reg;
            end
            else if (pos == `BCC_ENDIAN_BIT)
            begin : g_endian
                assign reg_view[pos] = little_endian;
            end
            else if (pos == `BCC_MEM_DRIVE_BIT)
            begin : g_mem
                assign reg_view[pos] = mem_drive_reg;
            end
            else if (pos == `BCC_CLK_DRIVE_BIT)
            begin : g_clk
                assign reg_view[pos] = clk_drive_reg;
            end
            else
            begin : g_fixed
                assign reg_view[pos] = FIXED_WORD[pos];
            end
        end
    endgenerate

    // Registered answer: ack or err in the cycle after the take edge, for one cycle
    assign ack_next   = take_hit;
    assign err_next   = take_miss;

    // Read data stands only in the ack cycle of a read; zero keeps stale values off the bus
    assign rdata_next = take_read ? reg_view : 32'h0;

    // Ack flop
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            ack_reg <= 1'b0;
        end
        else
        begin
            ack_reg <= ack_next;
        end
    end

    // Error flop for unmapped addresses
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            err_reg <= 1'b0;
        end
        else
        begin
            err_reg <= err_next;
        end
    end

    // Read data flop
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            rdata_reg <= 32'h0;
        end
        else
        begin
            rdata_reg <= rdata_next;
        end
    end

    // Bus outputs straight from flops
    assign wb_dat_o = rdata_reg;
    assign wb_ack_o = ack_reg;
    assign wb_err_o = err_reg;

    // One endian flag for all areas, no per-area override
    assign ctrl.map_select                = map_reg;
    assign ctrl.little_endian             = little_endian;
    assign ctrl.memory_pins_standby_drive = mem_drive_reg;
    assign ctrl.clock_pins_standby_drive  = clk_drive_reg;

    // Pin groups float in standby unless their drive bit is set; standby is taken as synchronous
    wire  [1:0]  drive_bits = {mem_drive_reg, clk_drive_reg};
    wire  [1:0]  group_oe;
    genvar       grp;
    generate
        for (grp = 0; grp < 2; grp++)
        begin : g_group
            assign group_oe[grp] = !standby || drive_bits[grp];
        end
    endgenerate

    // Into the carrier struct
    assign pin_oe.memory_pins_oe = group_oe[1];
    assign pin_oe.clock_pins_oe  = group_oe[0];
endmodule

// *** sim/bcc_mem_model.sv ***
// Far-side pin model: a floated pin reads as released
module bcc_mem_model(input wire bcc_pkg::bcc_pin_oe_t pin_oe, output wire [1:0] flt);
    timeunit 1ns / 1ns;
    // Memory and clock pins float whenever the controller lets go
    assign flt = ~pin_oe;
endmodule

// *** sim/bcc_common_control_assertions.sv ***
// Checker for the bus common control register
module bcc_chk(input wire logic clk, rst, wb_we_i, wb_ack_o, wb_err_o, standby,
    input wire logic [3:0] wb_sel_i, input wire logic [31:0] wb_dat_i, wb_dat_o,
    input wire bcc_pkg::bcc_ctrl_t ctrl, input wire bcc_pkg::bcc_pin_oe_t pin_oe);
    timeunit 1ns / 1ns;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // Answer strobes
    wire rd = wb_ack_o && !wb_we_i;
    wire wr = wb_ack_o && wb_we_i;
    a_fix_bits: assert property (rd |-> (wb_dat_o & 32'hffff_eff4) == 32'h14)
        else $error("fixed bits");
    a_map_read: assert property (rd |-> wb_dat_o[12] == ctrl.map_select)
        else $error("map read");
    a_end_read: assert property (rd |-> wb_dat_o[3] == ctrl.little_endian)
        else $error("endian read");
    a_end_hold: assert property (!$past(rst, 2) |-> $stable(ctrl.little_endian))
        else $error("endian moved");
    a_map_wr: assert property (wr && wb_sel_i[1] |=> ctrl.map_select == $past(wb_dat_i[12]))
        else $error("map write");
    a_drive_wr: assert property (wr && wb_sel_i[0] |=> ctrl[1:0] == $past(wb_dat_i[1:0]))
        else $error("drive write");
    a_pin_oe: assert property (pin_oe == ({2{!standby}} | ctrl[1:0]))
        else $error("pin enable");
    a_err_quiet: assert property (wb_err_o |-> (!wb_ack_o && $stable(ctrl)) ##1 $stable(ctrl))
        else $error("error write");
    cover property (wr && wb_sel_i == 4'h1);
    cover property (wb_err_o);
    cover property (standby && pin_oe == 2'h3);
    cover property (rd && wb_dat_o[3]);
endmodule
bind bcc_common_control bcc_chk bcc_chk_i(.clk, .rst, .wb_we_i, .wb_ack_o, .wb_err_o,
    .standby, .wb_sel_i, .wb_dat_i, .wb_dat_o, .ctrl, .pin_oe);

// *** sim/bcc_common_control_tb.sv ***
// Bench for the bus common control register
module bcc_common_control_tb;
    timeunit 1ns / 1ns;
    `define CHK(n, x, g) begin checks++; if ((g) !== (x)) begin n_mismatch++; \
        $display("wrong value %s exp %h got %h", n, x, g); end end
    logic clk = 0, rst = 1, cyc = 0, we = 0, s = 0, sb = 0, e, ack, err;
    logic [3:0] sel = 4'h0;
    logic [7:0] adr = 8'h00;
    logic [31:0] dat = 32'h0, q, rdat;
    wire [1:0] flt;
    bcc_pkg::bcc_ctrl_t ctrl;
    bcc_pkg::bcc_pin_oe_t oe;
    int n_mismatch = 0, checks = 0;
    initial forever #50 clk = ~clk;
    bcc_common_control bcc_common_control_i(.clk, .rst, .wb_cyc_i(cyc), .wb_stb_i(cyc),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .wb_err_o(err), .byte_order_strap_pin(s), .standby(sb), .ctrl,
        .pin_oe(oe));
    bcc_mem_model bcc_mem_model_i(.pin_oe(oe), .flt);
    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // One classic cycle, released only after the answer edge
    task automatic b(input logic w, input logic [7:0] a, input logic [31:0] d, logic [3:0] m);
        int n = 0;
        @(posedge clk);
        {cyc, we, adr, dat, sel} <= {1'b1, w, a, d, m};
        do @(posedge clk); while (ack !== 1'b1 && err !== 1'b1 && ++n < 20);
        e = err;
        q = rdat;
        cyc <= 0;
        n_mismatch += (n == 20);
        if (n == 20) finish_test;
    endtask
    task automatic rd(input string m, input logic [31:0] x);
        b(0, 8'h00, 32'h0, 4'hf);
        `CHK(m, x, q)
    endtask
    task automatic t_reset(input logic v);
        {s, rst} <= {v, 1'b1};
        repeat (12) @(posedge clk);
        rst <= 0;
        rd("reset", 32'h14 | {v, 3'h0});
        `CHK("endian", v, ctrl.little_endian)
    endtask
    // Writes that try every field, a lane gate and an unmapped place
    task automatic t_write;
        b(1, 8'h00, 32'hffff_ffff, 4'hf);
        rd("ones", 32'h1017 | {s, 3'h0});
        b(1, 8'h00, 32'h14, 4'h1);
        rd("lanes", 32'h1014 | {s, 3'h0});
        b(1, 8'h04, 32'h14, 4'hf);
        `CHK("err", 1'b1, e)
        b(1, 8'h00, 32'h14, 4'hf);
        rd("clear", 32'h14 | {s, 3'h0});
    endtask
    task automatic t_standby;
        @(negedge clk);
        `CHK("awake", 2'h0, flt)
        for (int i = 0; i < 4; i++)
        begin
            b(1, 8'h00, 32'h1014 | i, 4'hf);
            sb <= 1;
            repeat (2) @(negedge clk);
            `CHK("standby", ~i[1:0], flt)
        end
    endtask
    initial
    begin
        t_reset(0);
        t_write;
        t_standby;
        t_reset(1);
        t_write;
        finish_test;
    end
endmodule
